/* File: core/flash_ctrl.sv */
// flash controller end: wishbone registers drive serial frames
`timescale 1ns/10ps
module flash_ctrl
   import flash_pkg::*;
(
   input  wire logic        I_SYS_CLK,
   input  wire logic        I_RESET,
   input  wire logic        I_CLK_EN,
   input  wire logic        I_WB_CYC,
   input  wire logic        I_WB_STB,
   input  wire logic        I_WB_WE,
   input  wire logic [7:0]  I_WB_ADR,
   input  wire logic [3:0]  I_WB_SEL,
   input  wire logic [31:0] I_WB_DAT,
   output logic [31:0]      O_WB_DAT,
   output logic             O_WB_ACK,
   flash_link_if.ctrl       LINK
);
   import flash_pkg::*;

   typedef enum {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TRAIL, H_GAP} hstate_t;

   hstate_t     hstate;
   logic [31:0] cmd;
   logic [23:0] addr;
   logic [31:0] rx;
   logic [8:0]  wr_ptr;
   logic [12:0] bit_idx;
   logic [15:0] cnt;
   logic [1:0]  so_s;
   logic        sel_n;
   logic        sck;
   logic        si;
   logic [7:0]  tx_mem [TX_BYTES];

   // ****************************************
   // register decode
   // ****************************************
   wire        wb_req    = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
   wire        wb_wr     = wb_req & I_WB_WE;
   wire [31:0] lane_mask = {{8{I_WB_SEL[3]}}, {8{I_WB_SEL[2]}}, {8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};
   wire        busy      = (hstate != H_IDLE);
   wire        go        = wb_wr & (I_WB_ADR == REG_CMD) & I_WB_SEL[2] & I_WB_DAT[CMD_GO] & ~busy;
   wire [31:0] cmd_rd    = {9'h000, busy, 1'b0, cmd[20:0]};
   wire [31:0] rd_mux    = (I_WB_ADR == REG_CMD)  ? cmd_rd :
                           (I_WB_ADR == REG_ADDR) ? {8'h00, addr} :
                           (I_WB_ADR == REG_RX)   ? rx : 32'h0000_0000;
   wire        with_addr = cmd[CMD_WITH_ADDR];
   wire [12:0] total     = 13'd8 + (with_addr ? 13'd24 : 13'd0)
                           + {1'b0, cmd[CMD_COUNT_LSB+:9], 3'b000} + {10'h000, cmd[CMD_EXTRA_LSB+:3]};
   wire [9:0]  byte_idx  = bit_idx[12:3];
   wire [9:0]  data_idx  = byte_idx - (with_addr ? 10'd4 : 10'd1);
   wire [7:0]  cur_byte  = (byte_idx == 10'd0) ? cmd[7:0] :
                           (with_addr && byte_idx == 10'd1) ? addr[23:16] :
                           (with_addr && byte_idx == 10'd2) ? addr[15:8] :
                           (with_addr && byte_idx == 10'd3) ? addr[7:0] : tx_mem[data_idx[8:0]];
   wire        cur_bit   = cur_byte[~bit_idx[2:0]];
   wire [15:0] gap       = (cmd[7:0] != OP_WAKE) ? 16'(HOST_GAP_CYCLES) :
                           (total > 13'd8) ? 16'(ID_WAKE_CYCLES + HOST_GAP_CYCLES) :
                           16'(WAKE_CYCLES + HOST_GAP_CYCLES);

   always_ff @(posedge I_SYS_CLK)
   begin
      if (I_RESET)
      begin
         O_WB_ACK <= 1'b0;
         O_WB_DAT <= 32'h0000_0000;
         cmd      <= CMD_RESET;
         addr     <= 24'h000000;
      end
      else if (I_CLK_EN)
      begin
         O_WB_ACK <= wb_req;
         O_WB_DAT <= rd_mux;
         if (wb_wr && (I_WB_ADR == REG_CMD) && !busy)
            cmd <= (cmd & ~lane_mask) | (I_WB_DAT & lane_mask & 32'h001f_ffff);
         if (wb_wr && (I_WB_ADR == REG_ADDR))
            addr <= (addr & ~lane_mask[23:0]) | (I_WB_DAT[23:0] & lane_mask[23:0]);
      end
   end

   // ****************************************
   // transmit byte store
   // ****************************************
   always_ff @(posedge I_SYS_CLK)
   begin
      if (I_CLK_EN && wb_wr && (I_WB_ADR == REG_DATA) && I_WB_SEL[0])
         tx_mem[wr_ptr] <= I_WB_DAT[7:0];
   end

   always_ff @(posedge I_SYS_CLK)
   begin
      if (I_RESET)
         wr_ptr <= 9'd0;
      else if (I_CLK_EN && (hstate == H_TRAIL))
         wr_ptr <= 9'd0;
      else if (I_CLK_EN && wb_wr && (I_WB_ADR == REG_DATA) && I_WB_SEL[0])
         wr_ptr <= wr_ptr + 9'd1;
   end

   // ****************************************
   // frame engine with divided serial clock
   // ****************************************
   always_ff @(posedge I_SYS_CLK)
   begin
      if (I_RESET)
      begin
         hstate  <= H_IDLE;
         sel_n   <= 1'b1;
         sck     <= 1'b0;
         si      <= 1'b0;
         cnt     <= 16'd0;
         bit_idx <= 13'd0;
         rx      <= 32'h0000_0000;
         so_s    <= 2'b00;
      end
      else if (I_CLK_EN)
      begin
         so_s <= {so_s[0], LINK.so};
         if (cnt != 16'd0)
            cnt <= cnt - 16'd1;
         case (hstate)
            H_IDLE:
               if (go)
               begin
                  hstate  <= H_LEAD;
                  sel_n   <= 1'b0;
                  bit_idx <= 13'd0;
                  cnt     <= 16'(SCK_HALF_CYCLES);
               end
            H_LEAD:
               if (cnt == 16'd0)
               begin
                  hstate <= H_LOW;
                  si     <= cur_bit;
                  cnt    <= 16'(SCK_HALF_CYCLES);
               end
            H_LOW:
               if (cnt == 16'd0)
               begin
                  hstate <= H_HIGH;
                  sck    <= 1'b1;
                  rx     <= {rx[30:0], so_s[1]};
                  cnt    <= 16'(SCK_HALF_CYCLES);
               end
            H_HIGH:
               if (cnt == 16'd0)
               begin
                  sck     <= 1'b0;
                  bit_idx <= bit_idx + 13'd1;
                  cnt     <= (bit_idx + 13'd1 == total) ? 16'(SCK_HALF_CYCLES) : 16'd0;
                  hstate  <= (bit_idx + 13'd1 == total) ? H_TRAIL : H_LEAD;
               end
            H_TRAIL:
               if (cnt == 16'd0)
               begin
                  hstate <= H_GAP;
                  sel_n  <= 1'b1;
                  cnt    <= gap;
               end
            H_GAP:
               if (cnt == 16'd0)
                  hstate <= H_IDLE;
            default:
               hstate <= H_IDLE;
         endcase
      end
   end

   assign LINK.sel_n = sel_n;
   assign LINK.sck   = sck;
   assign LINK.si    = si;
endmodule // flash_ctrl

/* File: core/flash_device.sv */
// serial flash device end: command decode, program and erase cycles
// What this block does
// - bare wake opcode leaves power-down after recovery
// - host keeps select high during wake recovery
// - wake plus three dummies shifts identifier out
// - identifier repeats until select rises
// - host waits identifier-wake recovery after id wake
// - wake or identifier ignored while busy
// - page program needs write-enable latch set
// - program frame is opcode, address, data
// - program data wraps within current page
// - only final 256 bytes are programmed
// - short frame leaves other page bytes untouched
// - program needs select rise on byte boundary
// - select rise starts timed program, busy shown
// - write-enable latch clears as cycle ends
// - protected page is not programmed
// - sector erase needs address and latch
// - erase needs select rise after address
// - protected sector is not erased
// - small block erase, refused if address protected
// - large block erase, refused if address protected
// - array erase sets all bytes to ff
// - array erase refused if anything protected
// - asleep device hears only the wake opcode
`timescale 1ns/10ps
module flash_device
   import flash_pkg::*;
#(
   parameter int PP_CYCLES = flash_pkg::PP_CYCLES_DEF,
   parameter int SE_CYCLES = flash_pkg::SE_CYCLES_DEF,
   parameter int BE_CYCLES = flash_pkg::BE_CYCLES_DEF,
   parameter int CE_CYCLES = flash_pkg::CE_CYCLES_DEF
)(
   input  wire logic        I_SYS_CLK,
   input  wire logic        I_RESET,
   input  wire logic        I_CLK_EN,
   input  wire logic [2:0]  I_PROTECT_LEVEL,
   input  wire logic [11:0] I_PEEK_ADDR,
   output logic [7:0]       O_PEEK_DATA,
   output logic             O_BUSY,
   output logic             O_WEL,
   output logic             O_ASLEEP,
   flash_link_if.flash      LINK
);
   import flash_pkg::*;

   typedef enum {ST_READY, ST_BUSY, ST_ASLEEP, ST_WAKING} state_t;

   // ****************************************
   // protection decode
   // ****************************************
   function automatic logic is_protected(input logic [2:0] lvl, input logic [23:0] a);
      logic [4:0] first;
      first = 5'd16 - (5'd1 << (lvl - 3'd1));
      return (lvl != 3'd0) && ((lvl >= 3'd5) || ({1'b0, a[PROT_BLOCK_LSB+:4]} >= first));
   endfunction

   state_t      state;
   logic [2:0]  sck_s;
   logic [1:0]  si_s;
   logic [1:0]  sel_s;
   logic        sel_q;
   logic [7:0]  shift;
   logic [2:0]  bit_in_byte;
   logic [2:0]  byte_cnt;
   logic [7:0]  opcode;
   logic [23:0] addr;
   logic [7:0]  col;
   logic [7:0]  out_sr;
   logic        so_q;
   logic        write_enable_latch;
   logic        kind_pp;
   logic [11:0] walk;
   logic        walk_done;
   logic [31:0] timer;
   logic [7:0]  page_buf [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] page_valid;
   logic [7:0]  mem [MEM_BYTES];

   // ****************************************
   // pin sampling and frame decode
   // ****************************************
   wire       sck_rise   = sck_s[1] & ~sck_s[2];
   wire       sck_fall   = ~sck_s[1] & sck_s[2];
   wire       selected   = ~sel_s[1];
   wire       sel_rise   = sel_s[1] & ~sel_q;
   wire       sel_fall   = ~sel_s[1] & sel_q;
   wire [7:0] next_shift = {shift[6:0], si_s[1]};
   wire       byte_end   = sck_rise & selected & (bit_in_byte == 3'd7);
   wire       complete   = (bit_in_byte == 3'd0);
   wire       ready      = (state == ST_READY);
   wire       prot       = is_protected(I_PROTECT_LEVEL, addr);
   wire       op_erase   = (opcode == OP_SECTOR_ERASE) | (opcode == OP_BLOCK32_ERASE)
                           | (opcode == OP_BLOCK64_ERASE);
   wire       op_chip    = (opcode == OP_ARRAY_ERASE_A) | (opcode == OP_ARRAY_ERASE_B);
   wire       one_byte   = (byte_cnt == 3'd1) & complete;
   wire       exec_wel   = ready & (opcode == OP_WRITE_ENABLE) & one_byte;
   wire       exec_pd    = ready & (opcode == OP_POWER_DOWN) & one_byte;
   wire       exec_pp    = ready & (opcode == OP_PROGRAM) & (byte_cnt == 3'd5) & complete
                           & write_enable_latch & ~prot;
   wire       exec_erase = ready & op_erase & (byte_cnt == 3'd4) & complete & write_enable_latch & ~prot;
   wire       exec_chip  = ready & op_chip & one_byte & write_enable_latch & (I_PROTECT_LEVEL == 3'd0);
   wire       wake_bare  = (state == ST_ASLEEP) & (opcode == OP_WAKE) & one_byte;
   wire       wake_id    = (state == ST_ASLEEP) & (opcode == OP_WAKE) & complete
                           & (byte_cnt >= 3'd4);
   wire       id_phase   = ((state == ST_READY) | (state == ST_ASLEEP)) & (opcode == OP_WAKE)
                           & (byte_cnt >= 3'd4);
   wire       sr_phase   = ((state == ST_READY) | (state == ST_BUSY)) & (opcode == OP_READ_STATUS)
                           & (byte_cnt >= 3'd1);
   wire [7:0] status     = {3'b000, I_PROTECT_LEVEL, write_enable_latch, state == ST_BUSY};
   wire [7:0] out_src    = id_phase ? ID_VALUE : status;
   wire       walk_last  = kind_pp ? (walk[7:0] == 8'hff) : (walk == 12'hfff);
   wire       pp_store   = byte_end & ready & (opcode == OP_PROGRAM) & (byte_cnt >= 3'd4);

   always_ff @(posedge I_SYS_CLK)
   begin
      if (I_RESET)
      begin
         sck_s <= 3'b000;
         si_s  <= 2'b00;
         sel_s <= 2'b11;
         sel_q <= 1'b1;
      end
      else if (I_CLK_EN)
      begin
         sck_s <= {sck_s[1:0], LINK.sck};
         si_s  <= {si_s[0], LINK.si};
         sel_s <= {sel_s[0], LINK.sel_n};
         sel_q <= sel_s[1];
      end
   end

   // ****************************************
   // shift in opcode, address and data
   // ****************************************
   always_ff @(posedge I_SYS_CLK)
   begin
      if (I_RESET)
      begin
         shift       <= 8'h00;
         bit_in_byte <= 3'd0;
         byte_cnt    <= 3'd0;
         opcode      <= 8'h00;
         addr        <= 24'h000000;
         col         <= 8'h00;
      end
      else if (I_CLK_EN)
      begin
         if (!selected)
         begin
            bit_in_byte <= 3'd0;
            byte_cnt    <= 3'd0;
         end
         else if (sck_rise)
         begin
            shift       <= next_shift;
            bit_in_byte <= bit_in_byte + 3'd1;
            if (byte_end)
            begin
               if (byte_cnt != 3'd5)
                  byte_cnt <= byte_cnt + 3'd1;
               if (byte_cnt == 3'd0)
                  opcode <= next_shift;
               if ((byte_cnt >= 3'd1) && (byte_cnt <= 3'd3))
                  addr <= {addr[15:0], next_shift};
               if (byte_cnt == 3'd3)
                  col <= next_shift;
               else if (byte_cnt >= 3'd4)
                  col <= col + 8'd1;
            end
         end
      end
   end

   // ****************************************
   // page buffer: last byte per column wins
   // ****************************************
   always_ff @(posedge I_SYS_CLK)
   begin
      if (pp_store && I_CLK_EN)
         page_buf[col] <= next_shift;
   end

   always_ff @(posedge I_SYS_CLK)
   begin
      if (I_RESET)
         page_valid <= '0;
      else if (I_CLK_EN && sel_fall && ready)
         page_valid <= '0;
      else if (I_CLK_EN && pp_store)
         page_valid[col] <= 1'b1;
   end

   // ****************************************
   // serial output on falling clock
   // ****************************************
   always_ff @(posedge I_SYS_CLK)
   begin
      if (I_RESET)
      begin
         out_sr <= 8'h00;
         so_q   <= 1'b0;
      end
      else if (I_CLK_EN && selected && sck_fall && (id_phase || sr_phase))
      begin
         if (complete)
         begin
            out_sr <= {out_src[6:0], 1'b0};
            so_q   <= out_src[7];
         end
         else
         begin
            out_sr <= {out_sr[6:0], 1'b0};
            so_q   <= out_sr[7];
         end
      end
   end

   // ****************************************
   // state, timer and write-enable latch
   // ****************************************
   always_ff @(posedge I_SYS_CLK)
   begin
      if (I_RESET)
      begin
         state     <= ST_READY;
         write_enable_latch       <= 1'b0;
         timer     <= 32'd0;
         kind_pp   <= 1'b0;
         walk      <= 12'h000;
         walk_done <= 1'b0;
      end
      else if (I_CLK_EN)
      begin
         case (state)
            ST_READY:
            begin
               walk      <= exec_pp ? {addr[11:8], 8'h00} : 12'h000;
               walk_done <= 1'b0;
               kind_pp   <= exec_pp;
               if (sel_rise && exec_wel)
                  write_enable_latch <= 1'b1;
               if (sel_rise && exec_pd)
                  state <= ST_ASLEEP;
               if (sel_rise && (exec_pp || exec_erase || exec_chip))
               begin
                  state <= ST_BUSY;
                  if (exec_pp)
                     timer <= 32'(PP_CYCLES);
                  else if (exec_chip)
                     timer <= 32'(CE_CYCLES);
                  else if (opcode == OP_SECTOR_ERASE)
                     timer <= 32'(SE_CYCLES);
                  else
                     timer <= 32'(BE_CYCLES);
               end
            end
            ST_BUSY:
            begin
               if (timer != 32'd0)
                  timer <= timer - 32'd1;
               if (!walk_done)
               begin
                  walk      <= walk + 12'd1;
                  walk_done <= walk_last;
               end
               if ((timer == 32'd0) && walk_done)
               begin
                  state <= ST_READY;
                  write_enable_latch   <= 1'b0;
               end
            end
            ST_ASLEEP:
            begin
               if (sel_rise && wake_bare)
               begin
                  state <= ST_WAKING;
                  timer <= 32'(WAKE_CYCLES);
               end
               else if (sel_rise && wake_id)
               begin
                  state <= ST_WAKING;
                  timer <= 32'(ID_WAKE_CYCLES);
               end
            end
            ST_WAKING:
            begin
               if (timer == 32'd0)
                  state <= ST_READY;
               else
                  timer <= timer - 32'd1;
            end
            default:
               state <= ST_READY;
         endcase
      end
   end

   // ****************************************
   // storage array and inspection port
   // ****************************************
   always_ff @(posedge I_SYS_CLK)
   begin
      if (I_CLK_EN && (state == ST_BUSY) && !walk_done)
      begin
         if (!kind_pp)
            mem[walk] <= 8'hff;
         else if (page_valid[walk[7:0]])
            mem[walk] <= page_buf[walk[7:0]];
      end
   end

   always_ff @(posedge I_SYS_CLK)
   begin
      if (I_RESET)
         O_PEEK_DATA <= 8'h00;
      else if (I_CLK_EN)
         O_PEEK_DATA <= mem[I_PEEK_ADDR];
   end

   assign O_BUSY   = (state == ST_BUSY);
   assign O_WEL    = write_enable_latch;
   assign O_ASLEEP = (state == ST_ASLEEP) | (state == ST_WAKING);
   assign LINK.so  = so_q;
endmodule // flash_device

/* File: core/flash_link_if.sv */
// serial link between flash controller and flash device
`timescale 1ns/10ps
interface flash_link_if;
   logic sel_n;
   logic sck;
   logic si;
   logic so;
   modport flash (input sel_n, input sck, input si, output so);
   modport ctrl  (output sel_n, output sck, output si, input so);
endinterface

/* File: core/flash_pkg.sv */
// shared constants for the serial flash device end and its controller end
package flash_pkg;
   // ****************************************
   // opcodes
   // ****************************************
   localparam logic [7:0] OP_WAKE          = 8'hab;
   localparam logic [7:0] OP_PROGRAM       = 8'h02;
   localparam logic [7:0] OP_SECTOR_ERASE  = 8'h20;
   localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
   localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
   localparam logic [7:0] OP_ARRAY_ERASE_A = 8'hc7;
   localparam logic [7:0] OP_ARRAY_ERASE_B = 8'h60;
   localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
   localparam logic [7:0] OP_READ_STATUS   = 8'h05;
   localparam logic [7:0] OP_POWER_DOWN    = 8'hb9;
   // arbitrary identifier value
   localparam logic [7:0] ID_VALUE         = 8'h5a;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS               = 25;
   localparam int WAKE_RECOVERY_TIME_NS       = 3000;
   localparam int ID_WAKE_RECOVERY_TIME_NS    = 5000;
   localparam int PAGE_PROGRAM_TIME_US        = 1000;
   localparam int SECTOR_ERASE_TIME_MS        = 100;
   localparam int BLOCK_ERASE_TIME_MS         = 500;
   localparam int ARRAY_ERASE_TIME_MS         = 8000;
   localparam int WAKE_CYCLES     = (WAKE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ID_WAKE_CYCLES  = (ID_WAKE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PP_CYCLES_DEF   = PAGE_PROGRAM_TIME_US * (1000 / CLK_PERIOD_NS);
   localparam int SE_CYCLES_DEF   = SECTOR_ERASE_TIME_MS * (1000000 / CLK_PERIOD_NS);
   localparam int BE_CYCLES_DEF   = BLOCK_ERASE_TIME_MS * (1000000 / CLK_PERIOD_NS);
   localparam int CE_CYCLES_DEF   = ARRAY_ERASE_TIME_MS * (1000000 / CLK_PERIOD_NS);
   localparam int SCK_HALF_CYCLES = 8;
   localparam int HOST_GAP_CYCLES = 8;
   // ****************************************
   // device storage and status layout
   // ****************************************
   localparam int MEM_BYTES        = 4096;
   localparam int PAGE_BYTES       = 256;
   localparam int SR_BUSY_BIT      = 0;
   localparam int SR_WEL_BIT       = 1;
   localparam int SR_PROT_LSB      = 2;
   localparam int PROT_BLOCK_LSB   = 16;
   // ****************************************
   // controller registers
   // ****************************************
   localparam logic [7:0] REG_CMD  = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_DATA = 8'h08;
   localparam logic [7:0] REG_RX   = 8'h0c;
   localparam int CMD_OPC_LSB      = 0;
   localparam int CMD_WITH_ADDR    = 8;
   localparam int CMD_COUNT_LSB    = 9;
   localparam int CMD_EXTRA_LSB    = 18;
   localparam int CMD_GO           = 21;
   localparam int CMD_BUSY         = 22;
   localparam logic [31:0] CMD_RESET = 32'h0000_0000;
   localparam int TX_BYTES         = 512;
endpackage

/* File: sim/serial_flash_program_erase_asserts.sv */
// concurrent checks on the flash link and device flags
`timescale 1ns/10ps
module serial_flash_program_erase_asserts (
   input wire logic I_SYS_CLK,
   input wire logic I_RESET,
   input wire logic sel_n,
   input wire logic sck,
   input wire logic O_BUSY,
   input wire logic O_WEL,
   input wire logic O_ASLEEP
);
   // ****
   // link and flag checks
   // ****
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (I_RESET);
   chk_busy_start: assert property ($rose(O_BUSY) |-> sel_n && $past(sel_n, 2) && !$past(sel_n, 8))
      else $error("busy start off select rise");
   chk_busy_wel: assert property ($rose(O_BUSY) |-> $past(O_WEL))
      else $error("cycle without latch");
   chk_busy_hold: assert property ($rose(O_BUSY) |=> O_BUSY [*8])
      else $error("busy too short");
   chk_wel_clear: assert property ($fell(O_BUSY) |-> !O_WEL)
      else $error("latch kept after cycle");
   chk_busy_wel_fixed: assert property (O_BUSY |-> !$rose(O_WEL))
      else $error("latch set while busy");
   chk_sleep_idle: assert property (O_ASLEEP |-> !O_BUSY)
      else $error("busy while asleep");
   chk_wake_wait: assert property ($fell(O_ASLEEP) |-> sel_n && $past(sel_n, 100))
      else $error("woke too early");
   chk_sck_idle: assert property (sel_n && $past(sel_n, 2) |-> !sck)
      else $error("clock moves while deselected");
endmodule // serial_flash_program_erase_asserts

/* File: sim/test_serial_flash_program_erase.sv */
// random and corner tests of the flash pair
`timescale 1ns/10ps
module test_serial_flash_program_erase;
   import flash_pkg::*;
   logic        clk;
   logic        rst;
   logic        en;
   logic [41:0] req;
   logic [31:0] rdat;
   logic        ack;
   logic [2:0]  prot;
   logic [11:0] paddr;
   logic [7:0]  pdata;
   logic        busy;
   logic        write_enable_latch;
   logic        asleep;
   logic [31:0] q;
   logic [7:0]  s;
   logic [7:0]  exp_pg [256];
   logic [7:0]  ops [4];
   int          bad_count;
   int          compares;
   int          i;
   int          j;
   int          k;
   // ****
   // pair under test
   // ****
   flash_link_if flash_link_if_inst ();
   flash_device #(.PP_CYCLES(300), .SE_CYCLES(5000), .BE_CYCLES(5000), .CE_CYCLES(5000)) flash_device_inst (
      .I_SYS_CLK(clk), .I_RESET(rst), .I_CLK_EN(en), .I_PROTECT_LEVEL(prot), .I_PEEK_ADDR(paddr),
      .O_PEEK_DATA(pdata), .O_BUSY(busy), .O_WEL(write_enable_latch), .O_ASLEEP(asleep), .LINK(flash_link_if_inst));
   flash_ctrl flash_ctrl_inst (.I_SYS_CLK(clk), .I_RESET(rst), .I_CLK_EN(en), .I_WB_CYC(req[41]),
      .I_WB_STB(req[41]), .I_WB_WE(req[40]), .I_WB_ADR(req[39:32]), .I_WB_SEL(4'hf), .I_WB_DAT(req[31:0]),
      .O_WB_DAT(rdat), .O_WB_ACK(ack), .LINK(flash_link_if_inst));
   serial_flash_program_erase_asserts serial_flash_program_erase_asserts_inst (.I_SYS_CLK(clk), .I_RESET(rst),
      .sel_n(flash_link_if_inst.sel_n), .sck(flash_link_if_inst.sck), .O_BUSY(busy), .O_WEL(write_enable_latch),
      .O_ASLEEP(asleep));
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ****
   // tasks
   // ****
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e)
      begin
         bad_count++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_flag(input logic g, input logic e);
      chk_val({31'h0, g}, {31'h0, e});
   endtask
   task automatic hang;
      bad_count++;
      wrap_up();
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      req <= {1'b1, w, a, d};
      for (n = 0; n < 16 && ack !== 1'b1; n++)
         @(posedge clk);
      q = rdat;
      req <= '0;
      if (n == 16) hang();
   endtask
   task automatic frame(input logic [7:0] op, input logic [23:0] a, input int cnt, input logic [2:0] ex);
      int n;
      logic wa;
      wa = op inside {OP_PROGRAM, OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE};
      wb(1'b1, REG_ADDR, {8'h00, a});
      wb(1'b1, REG_CMD, {10'h0, 1'b1, ex, cnt[8:0], wa, op});
      for (n = 0; n < 20000; n++)
      begin
         wb(1'b0, REG_CMD, 32'h0);
         if (q[CMD_BUSY] === 1'b0) break;
      end
      if (n == 20000) hang();
      repeat (3) @(posedge clk);
   endtask
   task automatic idle;
      int n;
      for (n = 0; n < 20000 && busy !== 1'b0; n++)
         @(posedge clk);
      if (n == 20000) hang();
   endtask
   task automatic peek(input logic [11:0] a, input logic [7:0] e);
      @(posedge clk);
      paddr <= a;
      repeat (2) @(posedge clk);
      chk_val({24'h0, pdata}, {24'h0, e});
   endtask
   function automatic logic [7:0] col(input logic [7:0] st, input int n);
      return st + n[7:0];
   endfunction
   task automatic put(input int cnt);
      logic [7:0] d;
      for (i = 0; i < cnt; i++)
      begin
         d = 8'($urandom);
         exp_pg[col(s, i)] = d;
         wb(1'b1, REG_DATA, {24'h0, d});
      end
   endtask
   task automatic chk_page(input logic [11:0] base);
      for (k = 0; k < 256; k++)
         peek(base + 12'(k), exp_pg[k]);
   endtask
   // ****
   // main sequence
   // ****
   initial
   begin
      req = '0;
      rst = 1'b1;
      en = 1'b1;
      prot = 3'h0;
      paddr = 12'h0;
      bad_count = 0;
      compares = 0;
      k = $urandom(32'hb2b7d935);
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      frame(OP_ARRAY_ERASE_A, 0, 0, 0);
      chk_flag(busy, 1'b0);
      frame(OP_WRITE_ENABLE, 0, 0, 0);
      frame(OP_ARRAY_ERASE_A, 0, 0, 0);
      chk_flag(busy, 1'b1);
      idle();
      chk_flag(write_enable_latch, 1'b0);
      peek(12'($urandom), 8'hff);
      $display("test array erase end");
      s = 8'($urandom);
      frame(OP_WRITE_ENABLE, 0, 0, 0);
      put(258);
      frame(OP_PROGRAM, {16'h0001, s}, 258, 0);
      chk_flag(busy, 1'b1);
      idle();
      chk_page(12'h100);
      exp_pg = '{default: 8'hff};
      s = 8'hfe;
      frame(OP_WRITE_ENABLE, 0, 0, 0);
      put(3);
      frame(OP_PROGRAM, 24'h0002fe, 3, 0);
      idle();
      chk_page(12'h200);
      $display("test program end");
      frame(OP_WRITE_ENABLE, 0, 0, 0);
      put(1);
      frame(OP_PROGRAM, 24'h000300, 1, 3);
      chk_flag(busy, 1'b0);
      frame(OP_SECTOR_ERASE, 24'h0, 0, 2);
      chk_flag(busy, 1'b0);
      prot <= 3'h1;
      put(1);
      frame(OP_PROGRAM, 24'h0f0000, 1, 0);
      chk_flag(busy, 1'b0);
      frame(OP_SECTOR_ERASE, 24'h0f0000, 0, 0);
      chk_flag(busy, 1'b0);
      frame(OP_ARRAY_ERASE_B, 0, 0, 0);
      chk_flag(busy, 1'b0);
      chk_flag(write_enable_latch, 1'b1);
      prot <= 3'h0;
      $display("test refusals end");
      ops = '{OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE, OP_ARRAY_ERASE_B};
      for (j = 0; j < 4; j++)
      begin
         frame(OP_WRITE_ENABLE, 0, 0, 0);
         wb(1'b1, REG_DATA, 32'h0);
         frame(OP_PROGRAM, 24'h000200, 1, 0);
         idle();
         frame(OP_WRITE_ENABLE, 0, 0, 0);
         frame(ops[j], 24'($urandom), 0, 0);
         chk_flag(busy, 1'b1);
         en <= 1'b0;
         repeat (20) @(posedge clk);
         en <= 1'b1;
         chk_flag(busy, 1'b1);
         frame(OP_WRITE_ENABLE, 0, 0, 0);
         frame(OP_POWER_DOWN, 0, 0, 0);
         frame(OP_WAKE, 0, 5, 0);
         chk_flag(busy & ~asleep, 1'b1);
         idle();
         chk_flag(write_enable_latch | asleep, 1'b0);
         peek(12'h200, 8'hff);
      end
      $display("test erase kinds end");
      frame(OP_POWER_DOWN, 0, 0, 0);
      frame(OP_WRITE_ENABLE, 0, 0, 0);
      chk_flag(write_enable_latch, 1'b0);
      frame(OP_WAKE, 0, 0, 0);
      chk_flag(asleep, 1'b0);
      frame(OP_POWER_DOWN, 0, 0, 0);
      for (j = 0; j < 5; j++)
         wb(1'b1, REG_DATA, 32'h0);
      frame(OP_WAKE, 0, 5, 0);
      wb(1'b0, REG_RX, 32'h0);
      chk_val({16'h0, q[15:0]}, {16'h0, ID_VALUE, ID_VALUE});
      chk_flag(asleep, 1'b0);
      $display("test wake end");
      wrap_up();
   end
endmodule // test_serial_flash_program_erase
